/* File: core/xfer_err_handler.sv */
// Babble, data buffer and host system error handling of a USB host
// Assumes all transaction and fault inputs come from logic on clk_sys
//
// Operation
// R1: transfer or packet overflow sets babble, event, halt; USB3 IN checks packet overflow against MPS only, not transfer length
// R2: babble leaves bus error counter unchanged
// R3: babble and buffer codes only in transfer events
// R4: reported length equals bytes actually written
// R5: software treats excess data lost, no retry
// R6: USB2 IN at EOF2 is frame babble
// R7: frame babble disables the root port
// R8: port disabled, change flag set, change event
// R9: never start OUT crossing microframe end
// R10: PID mismatch: no babble check or MPS only
// R11: PID mismatch: drop payload, still ACK
// R12: USB3 DPP over MPS is babble
// R13: overrun/underrun gives buffer event, counter kept
// R14: IN buffer error: send no handshake
// R15: OUT buffer error: corrupt CRC, not truncate
// R16: system bus fault sets host system error
// R17: host system error clears run/stop
// R18: host system error reported on a pin
// R19: internal faults: fatal optional, recoverable separate
// R20: software checks events, then host error flag
// R21: 2-bit retry down counter per endpoint
// R22: completion codes are parameters
// R23: halt holds until endpoint reset command
`timescale 1ns/100ps
`include "xfer_err_defs.svh"
module xfer_err_handler
  import xfer_err_pkg::*;
#(
  parameter logic [7:0] CC_SUCCESS = `CC_SUCCESS_DEF,  // R22
  parameter logic [7:0] CC_BUFFER  = `CC_BUFFER_DEF,
  parameter logic [7:0] CC_BABBLE  = `CC_BABBLE_DEF,
  parameter logic [7:0] CC_XACT    = `CC_XACT_DEF
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // Transaction from the link engine
  input  wire logic        xact_start,
  input  wire logic        xact_in,
  input  wire logic        xact_usb3,
  input  wire logic        rx_pid_mismatch,
  input  wire logic [15:0] xfer_remaining,
  input  wire logic [10:0] max_packet,
  input  wire logic [15:0] out_cycles,
  input  wire logic [15:0] eof_cycles_left,
  input  wire logic        rx_byte,
  input  wire logic        eof2_point,
  input  wire logic        buf_overrun,
  input  wire logic        buf_underrun,
  input  wire logic        xact_end,
  input  wire logic        xact_err,
  // System faults
  input  wire logic        sys_parity_err,
  input  wire logic        sys_master_abort,
  input  wire logic        sys_target_abort,
  input  wire logic        internal_fatal,
  input  wire logic        internal_fault,
  // Bus responses
  output logic             xact_grant,
  output logic             send_ack,
  output logic             send_no_handshake,
  output logic             corrupt_crc,
  output logic             rx_discard,
  // Events and status
  output logic             evt_valid,
  output logic      [7:0]  evt_code,
  output logic      [15:0] evt_length,
  output logic             evt_transfer,
  output logic             port_change_evt,
  output logic             port_enabled,
  output logic             ep_halted,
  output logic      [1:0]  bus_err_cnt,
  output logic             run_stop,
  output logic             system_error
);

  err_state_t s;
  err_state_t next_s;
  logic       wr_cmd;
  logic       wr_sts;
  logic       wr_port;
  logic       wr_ep;
  logic       sys_err_set;
  logic [15:0] mps16;

  // Register write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr_cmd  = wr_en && hit(addr, `ADDR_CMD);
  assign wr_sts  = wr_en && hit(addr, `ADDR_STS);
  assign wr_port = wr_en && hit(addr, `ADDR_PORT);
  assign wr_ep   = wr_en && hit(addr, `ADDR_EPCTL);
  assign mps16   = {5'h00, max_packet};
  // Fatal system access faults; internal fatal ones only when enabled
  assign sys_err_set = sys_parity_err || sys_master_abort || sys_target_abort
                       || (internal_fatal && s.int_fatal_sys);  // R16 R19

  // Next state of the whole block
  always_comb begin
    next_s           = s;
    next_s.evt_valid = 1'b0;
    next_s.grant     = 1'b0;
    next_s.ack       = 1'b0;
    next_s.no_hs     = 1'b0;
    next_s.crc       = 1'b0;
    next_s.discard   = 1'b0;
    next_s.pchg      = 1'b0;
    next_s.rdata     = 32'h0000_0000;
    // Command register
    if (wr_cmd) begin
      next_s.run      = wdata[`CMD_RUN];
      next_s.mps_only = wdata[`CMD_MPS_ONLY];
      next_s.int_fatal_sys = wdata[`CMD_INT_FATAL];
    end
    // Status flags: write one clears, a new fault wins
    next_s.sys_err = (s.sys_err && !(wr_sts && wdata[`STS_SYS_ERR])) || sys_err_set;  // R16
    next_s.ctl_err = (s.ctl_err && !(wr_sts && wdata[`STS_CTL_ERR]))
                     || internal_fault || (internal_fatal && !s.int_fatal_sys);  // R19
    if (sys_err_set) begin
      next_s.run = 1'b0;  // R17
    end
    // Port enable and change flag
    if (wr_port) begin
      next_s.port_en = wdata[`PORT_EN];
      if (wdata[`PORT_EN_CHG]) begin
        next_s.en_chg = 1'b0;
      end
    end
    // Endpoint retry limit and halt clearing
    if (wr_ep) begin
      next_s.err_lim = wdata[1:0];
      if (wdata[`EPCTL_RESET]) begin
        next_s.halt = 1'b0;  // R23
        next_s.bec  = wdata[1:0];  // R21
      end
    end
    // Transaction tracking
    case (s.state)
      ST_IDLE: begin
        if (xact_start && s.run && !s.halt && s.port_en) begin  // R23
          next_s.cnt   = 16'h0000;
          next_s.bufe  = 1'b0;
          next_s.mism  = rx_pid_mismatch;
          next_s.usb3  = xact_usb3;
          next_s.chk   = !rx_pid_mismatch || s.mps_only;  // R10
          next_s.limit = (rx_pid_mismatch || xact_usb3 || mps16 < xfer_remaining)
                         ? mps16 : xfer_remaining;  // R10 R12
          if (xact_in) begin
            next_s.state = ST_IN;
            next_s.grant = 1'b1;
          end else if (out_cycles <= eof_cycles_left) begin
            next_s.state = ST_OUT;  // R9
            next_s.grant = 1'b1;
          end
        end
      end
      ST_IN: begin
        if (!s.usb3 && eof2_point) begin
          // Frame babble: halt and take the port down
          next_s.state      = ST_IDLE;  // R6
          next_s.halt       = 1'b1;
          next_s.evt_valid  = 1'b1;
          next_s.evt_code   = CC_BABBLE;
          next_s.evt_length = s.mism ? 16'h0000 : s.cnt;
          if (s.port_en) begin
            next_s.port_en = 1'b0;  // R7 R8
            next_s.en_chg  = 1'b1;
            next_s.pchg    = 1'b1;
          end
        end else if (rx_byte && s.chk && s.cnt == s.limit) begin
          // Transfer-size or packet babble; only expected bytes were stored
          next_s.state      = ST_IDLE;  // R1 R12
          next_s.halt       = 1'b1;
          next_s.evt_valid  = 1'b1;
          next_s.evt_code   = CC_BABBLE;  // R3
          next_s.evt_length = s.mism ? 16'h0000 : s.cnt;  // R4
        end else if (xact_err) begin
          next_s.state = ST_IDLE;
        end else if (xact_end) begin
          next_s.state = ST_IDLE;
          if (s.bufe || buf_overrun) begin
            next_s.no_hs      = 1'b1;  // R14
            next_s.evt_valid  = 1'b1;  // R13
            next_s.evt_code   = CC_BUFFER;
            next_s.evt_length = 16'h0000;
          end else if (s.mism) begin
            next_s.ack     = 1'b1;  // R11
            next_s.discard = 1'b1;
          end else begin
            next_s.ack        = 1'b1;
            next_s.evt_valid  = 1'b1;
            next_s.evt_code   = CC_SUCCESS;
            next_s.evt_length = s.cnt;
          end
        end else begin
          if (rx_byte && s.cnt != 16'hFFFF) begin
            next_s.cnt = s.cnt + 16'h0001;
          end
          if (buf_overrun) begin
            next_s.bufe = 1'b1;
          end
        end
      end
      ST_OUT: begin
        if (buf_underrun && !s.bufe) begin
          next_s.bufe       = 1'b1;
          next_s.crc        = 1'b1;  // R15
          next_s.evt_valid  = 1'b1;  // R13
          next_s.evt_code   = CC_BUFFER;
          next_s.evt_length = 16'h0000;
        end
        if (xact_err || xact_end) begin
          next_s.state = ST_IDLE;
        end
        if (xact_end && !xact_err && !s.bufe && !buf_underrun) begin
          next_s.evt_valid  = 1'b1;
          next_s.evt_code   = CC_SUCCESS;
          next_s.evt_length = out_cycles;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase
    // Bus error counter: only transaction errors count down
    if (s.state != ST_IDLE && xact_err) begin
      if (s.bec == 2'h1) begin
        next_s.bec        = 2'h0;  // R21
        next_s.halt       = 1'b1;
        next_s.evt_valid  = 1'b1;
        next_s.evt_code   = CC_XACT;
        next_s.evt_length = 16'h0000;
      end else if (s.bec != 2'h0) begin
        next_s.bec = s.bec - 2'h1;  // R21
      end
    end else if (s.state != ST_IDLE && s.bec != 2'h0
                 && (next_s.ack || (next_s.evt_valid && next_s.evt_code == CC_SUCCESS))) begin
      // Only a clean completion reloads; babble and buffer errors leave it
      next_s.bec = s.err_lim;  // R2 R13
    end
    // Read data, valid in the cycle after the strobe
    if (rd_en) begin
      case (addr)
        `ADDR_CMD:   next_s.rdata = {29'h0, s.int_fatal_sys, s.mps_only, s.run};
        `ADDR_STS:   next_s.rdata = {29'h0, s.halt, s.ctl_err, s.sys_err};
        `ADDR_PORT:  next_s.rdata = {30'h0, s.en_chg, s.port_en};
        `ADDR_EPCTL: next_s.rdata = {30'h0, s.err_lim};
        `ADDR_EPSTS: next_s.rdata = {28'h0, s.bec, s.state};
        `ADDR_EVT:   next_s.rdata = {8'h00, s.evt_code, s.evt_length};
        default:     next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s         <= '0;
      s.state   <= ST_IDLE;
      s.err_lim <= `EPCTL_LIM_RST;
      s.bec     <= `EPCTL_LIM_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign rdata             = s.rdata;
  assign xact_grant        = s.grant;
  assign send_ack          = s.ack;
  assign send_no_handshake = s.no_hs;
  assign corrupt_crc       = s.crc;
  assign rx_discard        = s.discard;
  assign evt_valid         = s.evt_valid;
  assign evt_code          = s.evt_code;
  assign evt_length        = s.evt_length;
  assign evt_transfer      = s.evt_valid;  // R3
  assign port_change_evt   = s.pchg;
  assign port_enabled      = s.port_en;
  assign ep_halted         = s.halt;
  assign bus_err_cnt       = s.bec;
  assign run_stop          = s.run;
  assign system_error      = s.sys_err;  // R18

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_babble_halts;
    evt_valid && evt_code == CC_BABBLE |-> ep_halted;
  endproperty
  a_babble_halts: assert property (p_babble_halts) else $error("babble without halt");  // R1

  property p_babble_keeps_cnt;
    evt_valid && evt_code == CC_BABBLE |-> bus_err_cnt == $past(bus_err_cnt);
  endproperty
  a_babble_keeps_cnt: assert property (p_babble_keeps_cnt) else $error("babble moved counter");  // R2

  property p_babble_length;
    s.state == ST_IN && rx_byte && s.chk && s.cnt == s.limit && !eof2_point
      |=> evt_length <= $past(s.limit);
  endproperty
  a_babble_length: assert property (p_babble_length) else $error("babble length too big");  // R4

  property p_frame_babble;
    s.state == ST_IN && !s.usb3 && eof2_point && port_enabled
      |=> ep_halted && !port_enabled && s.en_chg && port_change_evt && evt_code == CC_BABBLE;
  endproperty
  a_frame_babble: assert property (p_frame_babble) else $error("frame babble mishandled");  // R6

  property p_out_fits;
    s.state == ST_IDLE && xact_start && !xact_in && out_cycles > eof_cycles_left |=> !xact_grant;
  endproperty
  a_out_fits: assert property (p_out_fits) else $error("OUT crosses frame end");  // R9

  property p_mismatch_ack;
    s.state == ST_IN && s.mism && xact_end && !xact_err && !eof2_point && !s.bufe && !buf_overrun
      && !(rx_byte && s.chk && s.cnt == s.limit) |=> send_ack && rx_discard && !evt_valid;
  endproperty
  a_mismatch_ack: assert property (p_mismatch_ack) else $error("mismatch not acked");  // R11

  property p_in_buf_nohs;
    send_no_handshake |-> !send_ack && evt_valid && evt_code == CC_BUFFER;
  endproperty
  a_in_buf_nohs: assert property (p_in_buf_nohs) else $error("buffer error handshake");  // R14

  property p_underrun_crc;
    s.state == ST_OUT && buf_underrun && !s.bufe |=> corrupt_crc ##1 !corrupt_crc;
  endproperty
  a_underrun_crc: assert property (p_underrun_crc) else $error("underrun not corrupted");  // R15

  property p_buf_keeps_cnt;
    s.state != ST_IDLE && xact_end && !xact_err && !wr_ep && (s.bufe || buf_overrun || buf_underrun)
      |=> bus_err_cnt == $past(bus_err_cnt);
  endproperty
  a_buf_keeps_cnt: assert property (p_buf_keeps_cnt) else $error("buffer error moved counter");  // R13

  property p_out_one_event;
    s.state == ST_OUT && s.bufe && xact_end && !xact_err |=> !evt_valid;
  endproperty
  a_out_one_event: assert property (p_out_one_event) else $error("second event after underrun");  // R15

  property p_hse_sets;
    sys_parity_err || sys_master_abort || sys_target_abort |=> system_error && !run_stop;
  endproperty
  a_hse_sets: assert property (p_hse_sets) else $error("fault not flagged");  // R16

  property p_hse_stops;
    system_error && !$past(system_error) |-> !run_stop;
  endproperty
  a_hse_stops: assert property (p_hse_stops) else $error("run kept on fault");  // R17

  property p_halt_blocks;
    ep_halted |=> !xact_grant;
  endproperty
  a_halt_blocks: assert property (p_halt_blocks) else $error("grant while halted");  // R23

  c_babble:    cover property (evt_valid && evt_code == CC_BABBLE);
  c_frame:     cover property (port_change_evt);
  c_buffer:    cover property (send_no_handshake);
  c_mismatch:  cover property (rx_discard);
  c_sys_error: cover property ($rose(system_error));

endmodule

/* File: core/xfer_err_defs.svh */
// Register map, field positions, reset values of the error handler
// Assumes byte addresses on an 8-bit register port
`ifndef XFER_ERR_DEFS_SVH
`define XFER_ERR_DEFS_SVH
`define ADDR_CMD        8'h00
`define ADDR_STS        8'h04
`define ADDR_PORT       8'h08
`define ADDR_EPCTL      8'h0C
`define ADDR_EPSTS      8'h10
`define ADDR_EVT        8'h14
`define CMD_RUN         0
`define CMD_MPS_ONLY    1
`define CMD_INT_FATAL   2
`define STS_SYS_ERR     0
`define STS_CTL_ERR     1
`define STS_HALT        2
`define PORT_EN         0
`define PORT_EN_CHG     1
`define EPCTL_RESET     8
`define EPCTL_LIM_RST   2'h3
`define CC_SUCCESS_DEF  8'h01
`define CC_BUFFER_DEF   8'h02
`define CC_BABBLE_DEF   8'h03
`define CC_XACT_DEF     8'h04
`endif

/* File: core/xfer_err_pkg.sv */
// Types of the transfer error handler
// Assumes widths fixed at a 16-bit transfer length
package xfer_err_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_IN, ST_OUT} xact_state_t;
  typedef struct packed {
    xact_state_t  state;
    logic [15:0]  cnt;
    logic [15:0]  limit;
    logic         chk;
    logic         mism;
    logic         usb3;
    logic         bufe;
    logic         run;
    logic         mps_only;
    logic         int_fatal_sys;
    logic         sys_err;
    logic         ctl_err;
    logic         halt;
    logic         port_en;
    logic         en_chg;
    logic [1:0]   err_lim;
    logic [1:0]   bec;
    logic         evt_valid;
    logic [7:0]   evt_code;
    logic [15:0]  evt_length;
    logic         grant;
    logic         ack;
    logic         no_hs;
    logic         crc;
    logic         discard;
    logic         pchg;
    logic [31:0]  rdata;
  } err_state_t;
endpackage

/* File: bench/usb_dev_model.sv */
// Attached device model: answers a granted IN with a burst of data bytes
// Assumes the bench sets byte count and spacing before the grant arrives
`timescale 1ns/100ps
module usb_dev_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Host side
  input  wire logic       xact_grant,
  input  wire logic [7:0] n_bytes,
  input  wire logic [3:0] gap,
  // Data toward the host
  output logic            rx_byte,
  output logic            busy
);
  logic [7:0] left;
  logic [3:0] spacing;

  // Byte pacing: prompt when gap is zero, slow otherwise
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_byte <= 1'h0;
      left    <= 8'h0;
      spacing <= 4'h0;
    end else begin
      rx_byte <= 1'h0;
      if (xact_grant) begin
        left    <= n_bytes;
        spacing <= gap;
      end else if (left != 8'h0) begin
        if (spacing != 4'h0) begin
          spacing <= spacing - 4'h1;
        end else begin
          rx_byte <= 1'h1;
          left    <= left - 8'h1;
          spacing <= gap;
        end
      end
    end
  end

  // Still sending, last pulse included
  assign busy = (left != 8'h0) || rx_byte;
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench of the transfer error handler
// Assumes the device model feeds rx_byte; bench drives link and fault pulses
`timescale 1ns/100ps
`include "xfer_err_defs.svh"
module tb_top;
  logic        clk_sys = 1'h0;
  logic        reset   = 1'h1;
  logic [7:0]  addr    = 8'h0;
  logic [31:0] wdata   = 32'h0;
  logic        wr_en   = 1'h0, rd_en = 1'h0;
  logic        xact_start = 1'h0, xact_in = 1'h0, xact_usb3 = 1'h0, rx_pid_mismatch = 1'h0;
  logic [15:0] xfer_remaining = 16'h0, out_cycles = 16'h0, eof_cycles_left = 16'h0014;
  logic [10:0] max_packet = 11'h0;
  logic [9:0]  lp      = 10'h0;
  logic [7:0]  n_bytes = 8'h0;
  logic [3:0]  gap     = 4'h0;
  logic [31:0] rdata;
  logic [7:0]  evt_code;
  logic [15:0] evt_length;
  logic [1:0]  bus_err_cnt;
  logic        rx_byte, dev_busy, xact_grant, send_ack, send_no_handshake, corrupt_crc, rx_discard;
  logic        evt_valid, evt_transfer, port_change_evt, port_enabled, ep_halted, run_stop, system_error;
  int          n_errors = 0, n_compared = 0;
  int          cnt [8];

  xfer_err_handler xfer_err_handler_i (
    .clk_sys, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .xact_start, .xact_in, .xact_usb3,
    .rx_pid_mismatch, .xfer_remaining, .max_packet, .out_cycles, .eof_cycles_left, .rx_byte,
    .eof2_point(lp[0]), .buf_overrun(lp[1]), .buf_underrun(lp[2]), .xact_end(lp[3]), .xact_err(lp[4]),
    .sys_parity_err(lp[5]), .sys_master_abort(lp[6]), .sys_target_abort(lp[7]), .internal_fatal(lp[8]),
    .internal_fault(lp[9]), .xact_grant, .send_ack, .send_no_handshake, .corrupt_crc, .rx_discard,
    .evt_valid, .evt_code, .evt_length, .evt_transfer, .port_change_evt, .port_enabled, .ep_halted,
    .bus_err_cnt, .run_stop, .system_error
  );

  usb_dev_model usb_dev_model_i (
    .clk_sys, .reset, .xact_grant, .n_bytes, .gap, .rx_byte, .busy(dev_busy)
  );

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Pulse counters: grant, ack, no handshake, crc, discard, event, port change, transfer event
  always @(posedge clk_sys) begin
    cnt[0] += xact_grant;
    cnt[1] += send_ack;
    cnt[2] += send_no_handshake;
    cnt[3] += corrupt_crc;
    cnt[4] += rx_discard;
    cnt[5] += evt_valid;
    cnt[6] += port_change_evt;
    cnt[7] += evt_transfer;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk_sys);
    wr_en <= 1'h0;
    #1;
  endtask

  // Read and compare the masked word
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge clk_sys);
    rd_en <= 1'h0;
    #1 d = rdata;
    chk(nm, d & m, e);
  endtask

  // Wait for the device to finish, then for the one-cycle response
  task automatic settle;
    int k;
    for (k = 0; k < 60 && dev_busy; k++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(input int b);
    @(posedge clk_sys);
    lp[b] <= 1'h1;
    @(posedge clk_sys);
    lp <= 10'h0;
    settle();
  endtask

  // Start a transaction with its qualifiers; nb bytes come back on IN
  task automatic xs(input logic i, input logic u, input logic m, input logic [15:0] tl,
                    input logic [10:0] mps, input logic [15:0] oc, input logic [7:0] nb);
    foreach (cnt[k]) cnt[k] = 0;
    @(posedge clk_sys);
    xact_start      <= 1'h1;
    xact_in         <= i;
    xact_usb3       <= u;
    rx_pid_mismatch <= m;
    xfer_remaining  <= tl;
    max_packet      <= mps;
    out_cycles      <= oc;
    n_bytes         <= nb;
    @(posedge clk_sys);
    xact_start <= 1'h0;
    repeat (2) @(posedge clk_sys);
    settle();
  endtask

  // Expected run is a few hundred cycles; 25000 cycles means a hang
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    rdc("sts_rst", `ADDR_STS, 32'h7, 32'h0);
    rdc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    rdc("epsts_cnt_rst", `ADDR_EPSTS, 32'hC, 32'hC);
    wr(`ADDR_CMD, 32'h1);
    wr(`ADDR_PORT, 32'h1);
    chk("port_on", port_enabled, 32'h1);
    // OUT that would cross the microframe end is never started
    xs(1'h0, 1'h0, 1'h0, 16'h40, 11'h40, 16'h001E, 8'h0);
    chk("out_cross_grant", cnt[0], 32'h0);
    // Transaction error decrements, transfer-size babble with a slow device keeps the count
    xs(1'h1, 1'h0, 1'h0, 16'h10, 11'h8, 16'h0, 8'h0);
    pulse(4);
    chk("cnt_dec", bus_err_cnt, 32'h2);
    gap = 4'h3;
    xs(1'h1, 1'h0, 1'h0, 16'h2, 11'h8, 16'h0, 8'h3);
    gap = 4'h0;
    chk("size_bab_code", evt_code, `CC_BABBLE_DEF);
    chk("size_bab_len", evt_length, 32'h2);
    chk("size_bab_halt", ep_halted, 32'h1);
    chk("size_bab_cnt", bus_err_cnt, 32'h2);
    chk("size_bab_xfer", cnt[7], 32'h1);
    xs(1'h1, 1'h0, 1'h0, 16'h8, 11'h8, 16'h0, 8'h0);
    chk("halt_grant", cnt[0], 32'h0);
    wr(`ADDR_EPCTL, 32'h103);
    chk("ep_rst", ep_halted, 32'h0);
    chk("cnt_load", bus_err_cnt, 32'h3);
    // Successful IN
    xs(1'h1, 1'h0, 1'h0, 16'h4, 11'h8, 16'h0, 8'h2);
    pulse(3);
    chk("ok_code", evt_code, `CC_SUCCESS_DEF);
    chk("ok_len", evt_length, 32'h2);
    chk("ok_ack", cnt[1], 32'h1);
    // USB3 data packet over max packet size
    xs(1'h1, 1'h1, 1'h0, 16'h64, 11'h2, 16'h0, 8'h3);
    chk("u3_bab_code", evt_code, `CC_BABBLE_DEF);
    chk("u3_bab_halt", ep_halted, 32'h1);
    wr(`ADDR_EPCTL, 32'h103);
    // PID mismatch: check off, payload dropped, still acknowledged
    xs(1'h1, 1'h0, 1'h1, 16'h1, 11'h8, 16'h0, 8'h3);
    pulse(3);
    chk("mm_halt", ep_halted, 32'h0);
    chk("mm_ack", cnt[1], 32'h1);
    chk("mm_disc", cnt[4], 32'h1);
    // PID mismatch checked against max packet size only
    wr(`ADDR_CMD, 32'h3);
    xs(1'h1, 1'h0, 1'h1, 16'h1, 11'h2, 16'h0, 8'h3);
    chk("mm_mps_code", evt_code, `CC_BABBLE_DEF);
    chk("mm_mps_len", evt_length, 32'h0);
    wr(`ADDR_EPCTL, 32'h103);
    wr(`ADDR_CMD, 32'h1);
    // IN overrun: no handshake, buffer code, counter kept
    xs(1'h1, 1'h0, 1'h0, 16'h8, 11'h8, 16'h0, 8'h0);
    pulse(4);
    xs(1'h1, 1'h0, 1'h0, 16'h8, 11'h8, 16'h0, 8'h1);
    pulse(1);
    pulse(3);
    chk("ovr_nohs", cnt[2], 32'h1);
    chk("ovr_ack", cnt[1], 32'h0);
    chk("ovr_code", evt_code, `CC_BUFFER_DEF);
    chk("ovr_cnt", bus_err_cnt, 32'h2);
    // OUT underrun: tail corrupted, one event only
    xs(1'h0, 1'h0, 1'h0, 16'h8, 11'h8, 16'h000A, 8'h0);
    pulse(2);
    pulse(3);
    chk("udr_crc", cnt[3], 32'h1);
    chk("udr_code", evt_code, `CC_BUFFER_DEF);
    chk("udr_evts", cnt[5], 32'h1);
    // Frame babble at the end of frame point
    xs(1'h1, 1'h0, 1'h0, 16'h8, 11'h8, 16'h0, 8'h0);
    pulse(0);
    chk("frm_code", evt_code, `CC_BABBLE_DEF);
    chk("frm_halt", ep_halted, 32'h1);
    chk("frm_port", port_enabled, 32'h0);
    chk("frm_pchg", cnt[6], 32'h1);
    rdc("frm_en_chg", `ADDR_PORT, 32'h3, 32'h2);
    wr(`ADDR_PORT, 32'h3);
    wr(`ADDR_EPCTL, 32'h103);
    // Each system bus fault sets the error flag and stops the schedule
    for (int b = 5; b < 8; b++) begin
      wr(`ADDR_CMD, 32'h1);
      pulse(b);
      chk("sys_pin", system_error, 32'h1);
      chk("sys_run", run_stop, 32'h0);
      rdc("sys_sts", `ADDR_STS, 32'h1, 32'h1);
      wr(`ADDR_STS, 32'h1);
    end
    xs(1'h1, 1'h0, 1'h0, 16'h8, 11'h8, 16'h0, 8'h0);
    chk("stop_grant", cnt[0], 32'h0);
    // Internal faults: recoverable flag, or fatal when enabled
    wr(`ADDR_CMD, 32'h1);
    pulse(9);
    pulse(8);
    rdc("ctl_sts", `ADDR_STS, 32'h3, 32'h2);
    chk("ctl_run", run_stop, 32'h1);
    wr(`ADDR_CMD, 32'h5);
    pulse(8);
    chk("fatal_pin", system_error, 32'h1);
    report_and_stop();
  end
endmodule
